// ==== scg_pkg.sv ====
// Types shared by the clock unit modules
`default_nettype none
package scg_pkg;
  typedef enum logic [2:0] {
    SCG_SRC_NONE = 3'b000,
    SCG_SRC_FALLBACK = 3'b001,
    SCG_SRC_DIV3 = 3'b010,
    SCG_SRC_X2 = 3'b011,
    SCG_SRC_X4 = 3'b100,
    SCG_SRC_X6 = 3'b101,
    SCG_SRC_X8 = 3'b110,
    SCG_SRC_X12 = 3'b111
  } scg_src_type;

  typedef enum logic [1:0] {
    SCG_PLL_IDLE = 2'b00,
    SCG_PLL_SETTLE = 2'b01,
    SCG_PLL_READY = 2'b10
  } scg_pll_state_type;
endpackage : scg_pkg
`default_nettype wire

// ==== scg_pll_settle.sv ====
// PLL settle counter run on fallback clock strobes
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.svh"
module scg_pll_settle
  import scg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic fb_tick_i,
  output logic ready_o
);
  scg_pll_state_type state_q;
  logic [7:0] cnt_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= SCG_PLL_IDLE;
      cnt_q <= 8'h00;
      ready_o <= 1'b0;
    end else if (ce_i) begin
      case (state_q)
        SCG_PLL_IDLE: begin
          cnt_q <= 8'h00;
          ready_o <= 1'b0;
          if (enable_i) begin
            state_q <= SCG_PLL_SETTLE;
          end
        end
        SCG_PLL_SETTLE: begin
          if (!enable_i) begin
            state_q <= SCG_PLL_IDLE;
          end else if (fb_tick_i) begin
            if (cnt_q == `SCG_PLL_SETTLE_LAST) begin // R27
              state_q <= SCG_PLL_READY;
              ready_o <= 1'b1; // R3
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
        SCG_PLL_READY: begin
          if (!enable_i) begin
            state_q <= SCG_PLL_IDLE;
            ready_o <= 1'b0;
          end
        end
        default: begin
          state_q <= SCG_PLL_IDLE;
          ready_o <= 1'b0;
        end
      endcase
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_SETTLE_COUNT: assert property ($rose(ready_o) |-> $past(cnt_q) == `SCG_PLL_SETTLE_LAST) // R27
    else $error("PLL ready before full settle count");
  AST_SETTLE_DROP: assert property (ce_i && !enable_i |=> !ready_o) // R3
    else $error("PLL ready while PLL disabled");
  CVR_SETTLED: cover property ($rose(ready_o));
endmodule : scg_pll_settle
`default_nettype wire

// ==== scg_regs.svh ====
// Register offsets, field positions, reset values and division counts of the clock unit
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

`define SCG_ADDR_POWER 8'h99
`define SCG_ADDR_CLKSEL 8'h9a
`define SCG_ADDR_ANALOG 8'hc5
`define SCG_RESET_POWER 8'h00
`define SCG_RESET_CLKSEL 8'h00
`define SCG_RESET_ANALOG 8'h00

`define SCG_CKC_PLL_MODE_BIT 7
`define SCG_CKC_XTAL_BIT 6
`define SCG_PWR_SYS_OFF_BIT 7
`define SCG_PWR_DSP_ON_BIT 4
`define SCG_ANA_PLL_ON_BIT 5
`define SCG_ANA_MIC_BIT 4
`define SCG_ALT_AUX_EN_BIT 3
`define SCG_ALT_AUX_SRC_BIT 2

`define SCG_PLL_SETTLE_US 40
`define SCG_PLL_SETTLE_PERIODS 8'had
`define SCG_PLL_SETTLE_LAST 8'hac

`define SCG_DIV_X12 9'h002
`define SCG_DIV_X8 9'h003
`define SCG_DIV_X6 9'h004
`define SCG_DIV_X4 9'h006
`define SCG_DIV_X2 9'h00c
`define SCG_DIV_DIV3 9'h048
`define SCG_DIV_PHASE 9'h006
`define SCG_DIV_BIT_HALF 9'h009
`define SCG_BITS_PER_FRAME 8'hc0
`define SCG_DIV_CODEC_FRAME 9'h1b0
`define SCG_CORR_LAST 5'h18

`endif

// ==== scg_tick_div.sv ====
// Strobe divider: one output pulse for every ratio input strobes, restartable
`timescale 1ns/1ps
`default_nettype none
module scg_tick_div (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic resync_i,
  input wire logic [8:0] ratio_i,
  output logic tick_o
);
  logic [8:0] cnt_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 9'h000;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (resync_i) begin
        cnt_q <= 9'h000;
        tick_o <= 1'b0;
      end else if (tick_i) begin
        if (cnt_q >= ratio_i - 9'h001) begin
          cnt_q <= 9'h000;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 9'h001;
          tick_o <= 1'b0;
        end
      end else begin
        tick_o <= 1'b0;
      end
    end
  end
endmodule : scg_tick_div
`default_nettype wire

// ==== scg_top.sv ====
// Clock generation and selection unit with its three special function registers
//
// Function
// (R1) Input section scales crystal to PLL reference
// (R2) Software disables PLL only in emergency mode
// (R3) Stay on fallback until 173 periods settled
// (R4) Frame sync resync only in slave mode
// (R5) Master mode divides eight-times clock for bus
// (R6) Slave mode passes external bus clock, sync
// (R7) Register bit 3 enables auxiliary clock pin
// (R8) Register bit 2 picks auxiliary clock source
// (R9) Software sets aux source before enabling
// (R10) PLL gives twelve and eight times reference
// (R11) PLL gives six and four times reference
// (R12) Twice and one third reference for both
// (R13) Rate fixed codec clock is 24/25 reference
// (R14) Phase fixed codec clock from six-times clock
// (R15) Codec input clock is four times reference
// (R16) Crystal mode bit must match real reference
// (R17) Software uses 28 or 42 MHz DSP for bus
// (R18) Alternate crystal forces bus master mode
// (R19) Analog mode register at C5, reset zero
// (R20) Power config register at 99, reset zero
// (R21) Clock control register at 9A, reset zero
// (R22) Registers readable and writable by microcontroller
// (R23) Micro clock select with fallback in emergency
// (R24) DSP clock select, none when PLL off; code selects fallback while the PLL mode bit is clear
// (R25) Input select divides crystal by 1,2,4
// (R26) Frame tick divides frame strobe 16,8,4,1
// (R27) Settle counter on fallback gates PLL switchover
//
// Clocks other than the bus bit clocks and the aux clock pin are modelled as one-cycle strobes on core_clk_i; pll_vco_tick_i runs at
// 24 times the reference.
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.svh"
module scg_top
  import scg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [7:0] alt_port_select_i,
  input wire logic xtal_tick_i,
  input wire logic pll_vco_tick_i,
  input wire logic bus_slave_mode_i,
  input wire logic ext_bit_clock_i,
  input wire logic ext_frame_sync_i,
  output logic pll_enable_o,
  output logic pll_ready_o,
  output logic [2:0] dsp_src_o,
  output logic [2:0] micro_src_o,
  output logic dsp_clk_tick_o,
  output logic micro_clk_tick_o,
  output logic fallback_tick_o,
  output logic codec_clk_tick_o,
  output logic codec_input_tick_o,
  output logic codec_frame_strobe_o,
  output logic frame_tick_event_o,
  output logic bus_bit_clock_out_o,
  output logic bus_frame_sync_out_o,
  output logic bus_bit_clock_o,
  output logic bus_frame_sync_o,
  output logic aux_clock_output_o,
  output logic aux_clock_oe_o,
  output logic system_off_o,
  output logic dsp_enable_o,
  output logic mic_supply_en_o,
  output logic [3:0] codec_dig_en_o,
  output logic [3:0] codec_ana_en_o
);
  logic [7:0] power_clock_config_q;
  logic [7:0] clock_select_control_q;
  logic [7:0] analog_power_mode_q;
  logic fb_tick;
  logic pll_ready;
  logic pll_hold;
  logic x12_tick, x8_tick, x6_tick, x4_tick, x2_tick, div3_tick;
  logic phase_tick;
  logic corr_tick;
  logic [4:0] corr_cnt_q;
  logic half_tick;
  logic bclk_q;
  logic [7:0] bit_cnt_q;
  logic fsync_q;
  logic ext_fs_q;
  logic fs_rise;
  logic slave_eff;
  logic frame_resync;
  logic clk3_tick;
  logic frame_strobe;
  logic frame_event;
  logic sys_run;
  logic aux_src_tick;
  scg_src_type dsp_src;
  scg_src_type micro_src;
  logic dsp_tick;
  logic micro_tick;

  function automatic logic [8:0] input_ratio(input logic [1:0] code);
    case (code)
      2'b01: input_ratio = 9'h002;
      2'b10: input_ratio = 9'h004;
      default: input_ratio = 9'h001;
    endcase
  endfunction : input_ratio

  function automatic logic [8:0] frame_ratio(input logic [1:0] code);
    case (code)
      2'b00: frame_ratio = 9'h010;
      2'b01: frame_ratio = 9'h008;
      2'b10: frame_ratio = 9'h004;
      default: frame_ratio = 9'h001;
    endcase
  endfunction : frame_ratio

  function automatic logic src_tick(input scg_src_type src, input logic fb, input logic [5:0] pll);
    case (src)
      SCG_SRC_FALLBACK: src_tick = fb;
      SCG_SRC_DIV3: src_tick = pll[0];
      SCG_SRC_X2: src_tick = pll[1];
      SCG_SRC_X4: src_tick = pll[2];
      SCG_SRC_X6: src_tick = pll[3];
      SCG_SRC_X8: src_tick = pll[4];
      SCG_SRC_X12: src_tick = pll[5];
      default: src_tick = 1'b0;
    endcase
  endfunction : src_tick

  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      power_clock_config_q <= `SCG_RESET_POWER; // R20
      clock_select_control_q <= `SCG_RESET_CLKSEL; // R21
      analog_power_mode_q <= `SCG_RESET_ANALOG; // R19
    end else if (ce_i && sfr_wr_i) begin
      if (sfr_addr_i == `SCG_ADDR_POWER) begin
        power_clock_config_q <= sfr_wdata_i; // R20
      end else if (sfr_addr_i == `SCG_ADDR_CLKSEL) begin
        clock_select_control_q <= sfr_wdata_i; // R21
      end else if (sfr_addr_i == `SCG_ADDR_ANALOG) begin
        analog_power_mode_q <= sfr_wdata_i; // R19
      end
    end
  end

  // Register reads; other addresses belong to other blocks and read as zero here
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (!sfr_rd_i) begin
        sfr_rdata_o <= 8'h00;
      end else if (sfr_addr_i == `SCG_ADDR_POWER) begin
        sfr_rdata_o <= power_clock_config_q; // R22
      end else if (sfr_addr_i == `SCG_ADDR_CLKSEL) begin
        sfr_rdata_o <= clock_select_control_q; // R22
      end else if (sfr_addr_i == `SCG_ADDR_ANALOG) begin
        sfr_rdata_o <= analog_power_mode_q; // R22
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  assign system_off_o = power_clock_config_q[`SCG_PWR_SYS_OFF_BIT];
  assign dsp_enable_o = power_clock_config_q[`SCG_PWR_DSP_ON_BIT];
  assign codec_dig_en_o = power_clock_config_q[3:0];
  assign mic_supply_en_o = analog_power_mode_q[`SCG_ANA_MIC_BIT];
  assign codec_ana_en_o = analog_power_mode_q[3:0];
  assign pll_enable_o = analog_power_mode_q[`SCG_ANA_PLL_ON_BIT];
  assign pll_ready_o = pll_ready;
  assign sys_run = !power_clock_config_q[`SCG_PWR_SYS_OFF_BIT];

  // Crystal input scaled to the PLL reference
  scg_tick_div u_in_div (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(xtal_tick_i), .resync_i(1'b0),
    .ratio_i(input_ratio(analog_power_mode_q[7:6])), .tick_o(fb_tick) // R1 R25
  );

  scg_pll_settle u_settle (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .enable_i(analog_power_mode_q[`SCG_ANA_PLL_ON_BIT]), .fb_tick_i(fb_tick), .ready_o(pll_ready) // R27
  );

  // PLL derived strobes stay silent until the settle counter has expired
  assign pll_hold = !pll_ready; // R3

  scg_tick_div u_x12 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_X12), .tick_o(x12_tick) // R10
  );
  scg_tick_div u_x8 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_X8), .tick_o(x8_tick) // R10
  );
  scg_tick_div u_x6 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_X6), .tick_o(x6_tick) // R11
  );
  scg_tick_div u_x4 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_X4), .tick_o(x4_tick) // R11
  );
  scg_tick_div u_x2 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_X2), .tick_o(x2_tick) // R12
  );
  scg_tick_div u_div3 (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(pll_vco_tick_i), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_DIV3), .tick_o(div3_tick) // R12
  );

  // Alternate crystal gives bad slave timing, so slave mode is refused there
  assign slave_eff = bus_slave_mode_i && !clock_select_control_q[`SCG_CKC_XTAL_BIT]; // R18
  assign fs_rise = ext_frame_sync_i && !ext_fs_q;
  assign frame_resync = slave_eff && fs_rise; // R4

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_fs_q <= 1'b0;
    end else if (ce_i) begin
      ext_fs_q <= ext_frame_sync_i;
    end
  end

  scg_tick_div u_phase (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(x6_tick), .resync_i(pll_hold || frame_resync),
    .ratio_i(`SCG_DIV_PHASE), .tick_o(phase_tick) // R14
  );

  // Rate fixed codec clock: every 25th reference strobe is swallowed
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      corr_cnt_q <= 5'h00;
    end else if (ce_i && fb_tick) begin
      corr_cnt_q <= (corr_cnt_q == `SCG_CORR_LAST) ? 5'h00 : corr_cnt_q + 5'h01; // R13
    end
  end
  assign corr_tick = fb_tick && (corr_cnt_q != `SCG_CORR_LAST); // R13

  // Codec clock mux follows the crystal mode bit; a wrong bit gives wrong rates
  always_comb begin
    if (!clock_select_control_q[`SCG_CKC_PLL_MODE_BIT]) begin
      clk3_tick = fb_tick;
    end else if (clock_select_control_q[`SCG_CKC_XTAL_BIT]) begin
      clk3_tick = corr_tick; // R16
    end else begin
      clk3_tick = pll_ready ? phase_tick : fb_tick; // R16
    end
  end

  scg_tick_div u_frame (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(clk3_tick), .resync_i(frame_resync),
    .ratio_i(`SCG_DIV_CODEC_FRAME), .tick_o(frame_strobe) // R4
  );
  scg_tick_div u_frame_evt (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(frame_strobe), .resync_i(frame_resync),
    .ratio_i(frame_ratio(clock_select_control_q[1:0])), .tick_o(frame_event) // R26
  );

  // Bus master timing from the eight-times clock
  scg_tick_div u_bit_half (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(x8_tick), .resync_i(pll_hold),
    .ratio_i(`SCG_DIV_BIT_HALF), .tick_o(half_tick) // R5
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bclk_q <= 1'b0;
      bit_cnt_q <= 8'h00;
      fsync_q <= 1'b0;
    end else if (ce_i && half_tick) begin
      bclk_q <= !bclk_q; // R5
      if (bclk_q) begin
        bit_cnt_q <= (bit_cnt_q == `SCG_BITS_PER_FRAME - 8'h01) ? 8'h00 : bit_cnt_q + 8'h01;
        fsync_q <= (bit_cnt_q == `SCG_BITS_PER_FRAME - 8'h01); // R5
      end
    end
  end

  // Clock source selection
  always_comb begin
    if (!clock_select_control_q[`SCG_CKC_PLL_MODE_BIT] || !pll_ready) begin
      micro_src = SCG_SRC_FALLBACK; // R23
    end else begin
      case (clock_select_control_q[3:2])
        2'b00: micro_src = SCG_SRC_DIV3; // R23
        2'b01: micro_src = SCG_SRC_X2;
        2'b10: micro_src = SCG_SRC_X4;
        default: micro_src = SCG_SRC_X6;
      endcase
    end
  end

  always_comb begin
    if (!clock_select_control_q[`SCG_CKC_PLL_MODE_BIT]) begin
      dsp_src = SCG_SRC_FALLBACK; // R24
    end else if (!analog_power_mode_q[`SCG_ANA_PLL_ON_BIT]) begin
      dsp_src = SCG_SRC_NONE; // R24
    end else if (!pll_ready) begin
      dsp_src = SCG_SRC_FALLBACK; // R3
    end else begin
      case (clock_select_control_q[5:4])
        2'b00: dsp_src = SCG_SRC_DIV3; // R24
        2'b01: dsp_src = SCG_SRC_X2;
        2'b10: dsp_src = SCG_SRC_X12;
        default: dsp_src = SCG_SRC_X8;
      endcase
    end
  end

  assign micro_tick = src_tick(micro_src, fb_tick, {x12_tick, x8_tick, x6_tick, x4_tick, x2_tick, div3_tick});
  assign dsp_tick = src_tick(dsp_src, fb_tick, {x12_tick, x8_tick, x6_tick, x4_tick, x2_tick, div3_tick});
  assign aux_src_tick = alt_port_select_i[`SCG_ALT_AUX_SRC_BIT] ? micro_tick : fb_tick; // R8

  // Output strobes; system off gates every strobe in this block except the fallback strobe, DSP on gates the DSP clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dsp_src_o <= SCG_SRC_NONE;
      micro_src_o <= SCG_SRC_FALLBACK;
      dsp_clk_tick_o <= 1'b0;
      micro_clk_tick_o <= 1'b0;
      fallback_tick_o <= 1'b0;
      codec_clk_tick_o <= 1'b0;
      codec_input_tick_o <= 1'b0;
      codec_frame_strobe_o <= 1'b0;
      frame_tick_event_o <= 1'b0;
    end else if (ce_i) begin
      dsp_src_o <= dsp_src;
      micro_src_o <= micro_src;
      dsp_clk_tick_o <= sys_run && power_clock_config_q[`SCG_PWR_DSP_ON_BIT] && dsp_tick;
      micro_clk_tick_o <= sys_run && micro_tick;
      fallback_tick_o <= fb_tick;
      codec_clk_tick_o <= sys_run && clk3_tick;
      codec_input_tick_o <= sys_run && (pll_ready ? x4_tick : fb_tick); // R15
      codec_frame_strobe_o <= sys_run && frame_strobe;
      frame_tick_event_o <= sys_run && frame_event; // R26
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_bit_clock_out_o <= 1'b0;
      bus_frame_sync_out_o <= 1'b0;
      bus_bit_clock_o <= 1'b0;
      bus_frame_sync_o <= 1'b0;
    end else if (ce_i) begin
      bus_bit_clock_out_o <= bclk_q;
      bus_frame_sync_out_o <= fsync_q;
      bus_bit_clock_o <= slave_eff ? ext_bit_clock_i : bclk_q; // R6
      bus_frame_sync_o <= slave_eff ? ext_frame_sync_i : fsync_q; // R6
    end
  end

  // Source changes while enabled may glitch the pin; software sets the source first
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aux_clock_output_o <= 1'b0;
      aux_clock_oe_o <= 1'b0;
    end else if (ce_i) begin
      aux_clock_oe_o <= alt_port_select_i[`SCG_ALT_AUX_EN_BIT]; // R7
      if (!alt_port_select_i[`SCG_ALT_AUX_EN_BIT]) begin
        aux_clock_output_o <= 1'b0; // R7
      end else if (aux_src_tick) begin
        aux_clock_output_o <= !aux_clock_output_o; // R8
      end
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_EMG_MICRO: assert property (ce_i && !clock_select_control_q[7] |=> micro_src_o == SCG_SRC_FALLBACK) // R23
    else $error("micro clock not on fallback in emergency mode");
  AST_DSP_NOPLL: assert property (ce_i && clock_select_control_q[7] && !analog_power_mode_q[5] // R24
                                  |=> dsp_src_o == SCG_SRC_NONE && !dsp_clk_tick_o)
    else $error("DSP clock active with PLL off");
  AST_PLL_GATE: assert property (!pll_ready |=> ##1 !x12_tick && !x8_tick) // R3
    else $error("PLL strobe before settle");
  AST_SFR_READ: assert property (ce_i && sfr_rd_i && sfr_addr_i == `SCG_ADDR_CLKSEL // R22
                                 |=> sfr_rdata_o == $past(clock_select_control_q))
    else $error("clock control read mismatch");
  AST_SFR_WRITE: assert property (ce_i && sfr_wr_i && sfr_addr_i == `SCG_ADDR_ANALOG // R19
                                  |=> analog_power_mode_q == $past(sfr_wdata_i))
    else $error("analog mode write lost");
  AST_AUX_OFF: assert property (ce_i && !alt_port_select_i[3] |=> !aux_clock_output_o && !aux_clock_oe_o) // R7
    else $error("aux clock driven while disabled");
  AST_SLAVE_BITCLK: assert property (ce_i && slave_eff |=> bus_bit_clock_o == $past(ext_bit_clock_i)) // R6
    else $error("slave bit clock not passed through");
  AST_RATE_SWALLOW: assert property (ce_i && fb_tick && corr_cnt_q == `SCG_CORR_LAST // R13
                                     && clock_select_control_q[7:6] == 2'b11 |=> !codec_clk_tick_o)
    else $error("25th reference strobe not swallowed");
  AST_XTAL_MASTER: assert property (ce_i && clock_select_control_q[6] // R18
                                    |=> bus_bit_clock_o == bus_bit_clock_out_o)
    else $error("slave mode with alternate crystal");

  CVR_MICRO_PLL: cover property (micro_src_o == SCG_SRC_X6 ##1 micro_clk_tick_o);
  CVR_SLAVE_RESYNC: cover property (frame_resync ##[1:30] codec_clk_tick_o);
  CVR_AUX_RUN: cover property (aux_clock_oe_o && aux_clock_output_o);
  CVR_FRAME_EVT: cover property (frame_tick_event_o);
endmodule : scg_top
`default_nettype wire

// ==== scg_xtal_model.sv ====
// Crystal and PLL oscillator model feeding the clock unit with strobes
`timescale 1ns/1ps
`default_nettype none
module scg_xtal_model #(
  parameter int PER = 24
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic xtal_tick_o,
  output logic pll_vco_tick_o
);
  int cnt_q;
  // VCO runs at 24x reference, so with PER=24 it strobes every core cycle
  assign pll_vco_tick_o = 1'b1;
  assign xtal_tick_o = (cnt_q == PER - 1);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || cnt_q == PER - 1) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
endmodule : scg_xtal_model
`default_nettype wire

// ==== system_clock_generation_tb.sv ====
// Self-checking bench for the clock generation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module system_clock_generation_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, slv = 0, ebc = 0, efs = 0;
  logic [7:0] addr = 0, wd = 0, rdat, alt = 0;
  logic xt, vco, pen, prdy, dck, fsc, bck, bfs, aux, aoe, soff, den, mic;
  logic [2:0] dsrc, msrc;
  logic fbt, mt, dt, ct, cit, cfs, fte;
  logic [3:0] cde, cae;
  int n_fail = 0, total_checks = 0, cyc = 0, wt = 0;
  logic [2:0] mexp [4] = '{3'b010, 3'b011, 3'b100, 3'b101};
  logic [2:0] dexp [4] = '{3'b010, 3'b011, 3'b111, 3'b110};
  int mper [4] = '{72, 12, 6, 4};
  int dper [4] = '{72, 12, 2, 3};
  always #10 clk = ~clk;
  scg_xtal_model scg_xtal_model_inst (.core_clk_i(clk), .rst_i(rst), .xtal_tick_o(xt), .pll_vco_tick_o(vco));
  scg_top scg_top_inst (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .sfr_addr_i(addr), .sfr_wdata_i(wd),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdat), .alt_port_select_i(alt), .xtal_tick_i(xt),
    .pll_vco_tick_i(vco), .bus_slave_mode_i(slv), .ext_bit_clock_i(ebc), .ext_frame_sync_i(efs),
    .pll_enable_o(pen), .pll_ready_o(prdy), .dsp_src_o(dsrc), .micro_src_o(msrc), .dsp_clk_tick_o(dt),
    .micro_clk_tick_o(mt), .fallback_tick_o(fbt), .codec_clk_tick_o(ct), .codec_input_tick_o(cit),
    .codec_frame_strobe_o(cfs), .frame_tick_event_o(fte), .bus_bit_clock_out_o(dck),
    .bus_frame_sync_out_o(fsc), .bus_bit_clock_o(bck), .bus_frame_sync_o(bfs), .aux_clock_output_o(aux),
    .aux_clock_oe_o(aoe), .system_off_o(soff), .dsp_enable_o(den), .mic_supply_en_o(mic),
    .codec_dig_en_o(cde), .codec_ana_en_o(cae));
  task test_done;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Each task is entered just after a rising edge and leaves at one
  task wrt(input logic [7:0] a, input logic [7:0] d);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wrt
  task rdc(input logic [7:0] a, input logic [7:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 `CHK(rdat, e)
    @(posedge clk);
  endtask : rdc
  function logic pick(input int w);
    case (w)
      0: pick = fbt;
      1: pick = mt;
      2: pick = dt;
      3: pick = dck;
      4: pick = aux;
      5: pick = fsc;
      6: pick = ct;
      7: pick = cit;
      default: pick = fte;
    endcase
  endfunction : pick
  // Cycles between two rising edges of the chosen output
  task per(input int w, input int e);
    int n, k;
    logic p;
    n = 0; k = 0; p = 1'b1;
    while (k < 2 && n < e + 400) begin
      @(posedge clk) #1 n++;
      if (pick(w) === 1'b1 && p === 1'b0) begin k++; if (k == 1) n = 0; end
      p = pick(w);
    end
    `CHK(n, e)
    @(posedge clk);
  endtask : per
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin n_fail++; test_done(); end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h99, 8'h00);
    rdc(8'h9a, 8'h00);
    rdc(8'hc5, 8'h00);
    wrt(8'h55, 8'hff);
    rdc(8'h55, 8'h00);
    wrt(8'h99, 8'h7f);
    rdc(8'h99, 8'h7f);
    `CHK({soff, den, cde}, 6'h1f)
    wrt(8'hc5, 8'h1a);
    rdc(8'hc5, 8'h1a);
    `CHK({pen, mic, cae}, 6'h1a)
    `CHK(msrc, 3'b001)
    `CHK(dsrc, 3'b001)
    per(0, 24);
    wrt(8'hc5, 8'h5a);
    per(0, 48);
    wrt(8'hc5, 8'h9a);
    per(0, 96);
    wrt(8'hc5, 8'h3a);
    repeat (4070) @(posedge clk);
    `CHK(prdy, 1'b0)
    repeat (120) @(posedge clk);
    `CHK(prdy, 1'b1)
    for (int i = 0; i < 4; i++) begin
      wrt(8'h9a, 8'h80 | 8'(i << 2) | 8'(i << 4));
      `CHK(msrc, mexp[i])
      `CHK(dsrc, dexp[i])
      per(1, mper[i]);
      per(2, dper[i]);
    end
    per(3, 54);
    per(5, 10368);
    per(6, 24);
    per(7, 6);
    wrt(8'h9a, 8'hbf);
    per(8, 10368);
    slv <= 1'b1; ebc <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(bck, 1'b1)
    ebc <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(bck, 1'b0)
    efs <= 1'b1; wt = 2;
    repeat (2) @(posedge clk);
    `CHK(bfs, 1'b1)
    efs <= 1'b0;
    // Resync restarts the codec frame, so the next strobe lands one full frame after the rise
    do @(posedge clk) #1 wt++; while (cfs !== 1'b1 && wt < 11000);
    `CHK(wt >= 10366 && wt <= 10374, 1'b1)
    // Alternate crystal: slave request ignored, the master bit clock drives the bus
    @(posedge clk) ebc <= 1'b1;
    wrt(8'h9a, 8'hfc);
    @(negedge dck);
    @(posedge clk) #1 `CHK(bck, 1'b0)
    wt = 0;
    repeat (600) @(posedge clk) #1 if (ct === 1'b1) wt++;
    `CHK(wt, 24)
    @(posedge clk);
    slv <= 1'b0; alt <= 8'h04;
    @(posedge clk) alt <= 8'h0c;
    repeat (3) @(posedge clk);
    `CHK(aoe, 1'b1)
    per(4, 8);
    alt <= 8'h00;
    @(posedge clk) alt <= 8'h08;
    @(posedge clk);
    per(4, 48);
    wrt(8'h9a, 8'h00);
    wrt(8'hc5, 8'h00);
    wrt(8'h9a, 8'h80);
    `CHK(dsrc, 3'b000)
    `CHK(prdy, 1'b0)
    test_done();
  end
endmodule : system_clock_generation_tb
`undef CHK
`default_nettype wire
